// ### verilog/upd_mbox_regs.svh
// Purpose: Field positions, command codes, lengths and answer codes of the mailbox block.
// Assumes: Included by its bare name wherever a value is needed.
// Notes: Definitions only.
`ifndef UPD_MBOX_REGS_SVH
`define UPD_MBOX_REGS_SVH

// Header word layout, shared by command and response headers.
`define HDR_CODE_LSB 0
`define HDR_CODE_W 11
`define HDR_LEN_LSB 12
`define HDR_LEN_W 11
`define HDR_CLIENT_LSB 24
`define HDR_CLIENT_W 4

// Command codes.
`define CMD_UPDATE_STATUS 11'h05B
`define CMD_FLASH_CLAIM 11'h032
`define CMD_FLASH_RELEASE 11'h033
`define CMD_FLASH_SELECT 11'h034

// Argument and response lengths in words, header excluded.
`define LEN_NONE 11'h000
`define LEN_ONE 11'h001
`define RSP_LEN_STATUS 4'h9
`define RSP_LEN_FLASH 4'h1
`define RSP_LEN_ERROR 4'h0

// Answer codes placed in the code field of the response header.
`define RESP_OK 11'h000
`define RESP_UNKNOWN_CMD 11'h003
`define RESP_BAD_LENGTH 11'h004
`define RESP_RESOURCE_BUSY 11'h00B
`define RESP_NOT_OWNER 11'h100
`define RESP_BAD_SELECT 11'h101

// Status word 5 fields and encodings.
`define W5_INDEX_LSB 28
`define W5_SOURCE_LSB 16
`define W5_VERSION_LSB 0
`define ERRSRC_NONE 12'h000
`define ERRSRC_APP 12'hACF
`define ERRSRC_DECISION 12'hDCF

// Flash select argument and chip-select lines.
`define SEL_DEV_LSB 28
`define SEL_DEV_W 4
`define SEL_RSVD_W 28
`define SEL_MAX 4'h3
`define CS_LINES 4
`define CS_CONFIG_LINE 2'h0
`define CS_ALL_OFF 4'hF

// Retry limit bounds.
`define RETRY_LIMIT_MIN 2'h1
`define RETRY_LIMIT_MAX 2'h3

// Reset values.
`define RST_WORD 32'h0000_0000
`define RST_SEL 2'h0

`endif

// ### verilog/upd_mbox_pkg.sv
// Purpose: Shared types of the update-status and flash mailbox block.
// Assumes: Values live in upd_mbox_regs.svh.
// Notes: Types only.
package upd_mbox_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARGS = 4'h2,
        ST_EXEC = 4'h4,
        ST_RESP = 4'h8
    } cmd_state_t;
    typedef logic [10:0] code_t;
    typedef logic [3:0] client_t;
    typedef logic [31:0] word_t;
endpackage : upd_mbox_pkg

// ### verilog/status_if.sv
// Purpose: Carries status fields, the word index and the formed word between the block's modules.
// Assumes: One clock domain.
// Notes: The mux is purely combinational.
`timescale 1ns/100ps
interface status_if;
    logic [3:0] dcmf_index;
    logic [11:0] err_source;
    logic [7:0] if_version;
    logic [63:0] cur_image;
    logic [63:0] fail_image;
    logic [31:0] fail_state;
    logic [31:0] err_location;
    logic [31:0] err_details;
    logic [1:0] retry_count;
    logic [3:0] word_idx;
    logic [31:0] word;
    modport top (output dcmf_index, err_source, if_version, cur_image, fail_image, fail_state,
        err_location, err_details, word_idx, input retry_count, word);
    modport mux (input dcmf_index, err_source, if_version, cur_image, fail_image, fail_state,
        err_location, err_details, word_idx, retry_count, output word);
    modport retry (output retry_count);
endinterface : status_if

// ### verilog/retry_counter.sv
// Purpose: Counts retry attempts of the current image.
// Assumes: Retry and new-image strobes are one-cycle pulses on the same clock.
// Notes: A retry in the same cycle as a new image wins over the clear.
`timescale 1ns/100ps
`include "upd_mbox_regs.svh"
module retry_counter
    import upd_mbox_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic retry_event,
    input wire logic new_image,
    input wire logic [1:0] max_retry,
    output logic exhausted,
    status_if.retry sif
);
    logic [1:0] count_ff;
    logic [1:0] nxt_count;
    logic [1:0] limit;
    logic [1:0] allowed;

    always_comb begin
        // Out-of-range limits are clamped into 1..3 rather than refused.
        limit = max_retry;
        if (limit < `RETRY_LIMIT_MIN) begin
            limit = `RETRY_LIMIT_MIN;
        end
        allowed = limit - `RETRY_LIMIT_MIN;
        nxt_count = count_ff;
        if (retry_event) begin
            if (count_ff != `RETRY_LIMIT_MAX) begin
                nxt_count = count_ff + 2'h1;
            end
        end else if (new_image) begin
            nxt_count = 2'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_ff <= 2'h0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign exhausted = (count_ff >= allowed);
    assign sif.retry_count = count_ff;
endmodule : retry_counter

// ### verilog/status_word_mux.sv
// Purpose: Forms the nine status response words from the live status fields.
// Assumes: Word index 0 to 8; other indices read as zero.
// Notes: Words 6 and 7 read zero whenever no error is present.
`timescale 1ns/100ps
`include "upd_mbox_regs.svh"
module status_word_mux
    import upd_mbox_pkg::*;
(
    status_if.mux sif
);
    logic err_present;
    logic [11:0] src;

    always_comb begin
        err_present = (sif.err_source != `ERRSRC_NONE) || (sif.fail_image != 64'h0);
        // Unknown source encodings read as no error in word 5, yet words 6 and 7 still show location and details.
        src = `ERRSRC_NONE;
        if (sif.err_source == `ERRSRC_APP || sif.err_source == `ERRSRC_DECISION) begin
            src = sif.err_source;
        end
        case (sif.word_idx)
            4'h0: sif.word = sif.cur_image[31:0];
            4'h1: sif.word = sif.cur_image[63:32];
            4'h2: sif.word = sif.fail_image[31:0];
            4'h3: sif.word = sif.fail_image[63:32];
            4'h4: sif.word = sif.fail_state;
            4'h5: sif.word = {sif.dcmf_index, src, 8'h00, sif.if_version};
            4'h6: sif.word = err_present ? sif.err_location : `RST_WORD;
            4'h7: sif.word = err_present ? sif.err_details : `RST_WORD;
            4'h8: sif.word = {30'h0000_0000, sif.retry_count};
            default: sif.word = `RST_WORD;
        endcase
    end
endmodule : status_word_mux

// ### verilog/upd_flash_mailbox.sv
// Purpose: Mailbox command handler for the update-status query and flash ownership commands.
// Assumes: All inputs come from logic on REF_CLK; no synchronisers are needed.
// Notes: One command is handled at a time; the response is drained before the next header.
`timescale 1ns/100ps
`include "upd_mbox_regs.svh"
module upd_flash_mailbox
    import upd_mbox_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CMD_VALID,
    input wire logic [31:0] CMD_DATA,
    output logic CMD_READY,
    output logic RSP_VALID,
    output logic [31:0] RSP_DATA,
    output logic RSP_LAST,
    input wire logic RSP_READY,
    input wire logic [3:0] DCMF_INDEX,
    input wire logic [11:0] ERR_SOURCE,
    input wire logic [7:0] IF_VERSION,
    input wire logic [63:0] CUR_IMAGE,
    input wire logic [63:0] FAIL_IMAGE,
    input wire logic [31:0] FAIL_STATE,
    input wire logic [31:0] ERR_LOCATION,
    input wire logic [31:0] ERR_DETAILS,
    input wire logic RETRY_EVENT,
    input wire logic NEW_IMAGE,
    input wire logic [1:0] MAX_RETRY,
    output logic RETRY_EXHAUSTED,
    input wire logic CONFIG_BUSY,
    input wire logic CONFIG_FLASH_REQ,
    input wire logic QUAD_SCHEME,
    input wire logic FLASH_XFER,
    output logic FLASH_OWNED,
    output logic [3:0] FLASH_OWNER,
    output logic FLASH_ACCESS_OK,
    output logic [3:0] FLASH_CHIP_SELECTS_N
);
    status_if sif();

    cmd_state_t state_ff;
    cmd_state_t nxt_state;
    code_t code_ff;
    code_t nxt_code;
    logic [10:0] len_ff;
    logic [10:0] nxt_len;
    logic [10:0] args_left_ff;
    logic [10:0] nxt_args_left;
    client_t client_ff;
    client_t nxt_client;
    word_t arg0_ff;
    word_t nxt_arg0;
    logic cmd_ready_ff;
    logic nxt_cmd_ready;

    logic rsp_valid_ff;
    logic nxt_rsp_valid;
    word_t rsp_data_ff;
    word_t nxt_rsp_data;
    logic rsp_last_ff;
    logic nxt_rsp_last;
    logic [3:0] rsp_idx_ff;
    logic [3:0] nxt_rsp_idx;
    logic [3:0] rsp_len_ff;
    logic [3:0] nxt_rsp_len;
    logic body_status_ff;
    logic nxt_body_status;

    logic owned_ff;
    logic nxt_owned;
    client_t owner_ff;
    client_t nxt_owner;
    logic [1:0] sel_ff;
    logic [1:0] nxt_sel;
    logic selected_ff;
    logic nxt_selected;
    logic access_ok_ff;
    logic nxt_access_ok;
    logic [3:0] cs_n_ff;
    logic [3:0] nxt_cs_n;
    logic exhausted_ff;
    logic retry_exhausted;

    logic take;
    code_t verdict;
    logic [3:0] verdict_len;
    logic is_owner;

    // Builds a response header; the length field holds data words only.
    function automatic word_t make_hdr(input code_t code, input logic [3:0] len, input client_t client);
        word_t w;
        w = `RST_WORD;
        w[`HDR_CODE_LSB +: `HDR_CODE_W] = code;
        w[`HDR_LEN_LSB +: `HDR_LEN_W] = {7'h00, len};
        w[`HDR_CLIENT_LSB +: `HDR_CLIENT_W] = client;
        return w;
    endfunction : make_hdr

    // Turns a chip-select line number into an active-low select vector.
    function automatic logic [3:0] cs_vector(input logic [1:0] line);
        logic [3:0] v;
        v = `CS_ALL_OFF;
        v[line] = 1'b0;
        return v;
    endfunction : cs_vector

    assign sif.dcmf_index = DCMF_INDEX;
    assign sif.err_source = ERR_SOURCE;
    assign sif.if_version = IF_VERSION;
    assign sif.cur_image = CUR_IMAGE;
    assign sif.fail_image = FAIL_IMAGE;
    assign sif.fail_state = FAIL_STATE;
    assign sif.err_location = ERR_LOCATION;
    assign sif.err_details = ERR_DETAILS;
    // Body word k+1 of the status answer is status word k, so the current index is the word number.
    assign sif.word_idx = rsp_idx_ff;

    status_word_mux u_mux (
        .sif(sif.mux)
    );

    retry_counter u_retry (
        .ref_clk(REF_CLK),
        .rst_n(RST_N),
        .retry_event(RETRY_EVENT),
        .new_image(NEW_IMAGE),
        .max_retry(MAX_RETRY),
        .exhausted(retry_exhausted),
        .sif(sif.retry)
    );

    assign take = CMD_VALID && cmd_ready_ff;
    assign is_owner = owned_ff && (owner_ff == client_ff);

    always_comb begin
        nxt_state = state_ff;
        nxt_code = code_ff;
        nxt_len = len_ff;
        nxt_args_left = args_left_ff;
        nxt_client = client_ff;
        nxt_arg0 = arg0_ff;
        nxt_rsp_valid = rsp_valid_ff;
        nxt_rsp_data = rsp_data_ff;
        nxt_rsp_last = rsp_last_ff;
        nxt_rsp_idx = rsp_idx_ff;
        nxt_rsp_len = rsp_len_ff;
        nxt_body_status = body_status_ff;
        nxt_owned = owned_ff;
        nxt_owner = owner_ff;
        nxt_sel = sel_ff;
        nxt_selected = selected_ff;
        verdict = `RESP_OK;
        verdict_len = `RSP_LEN_ERROR;
        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_code = CMD_DATA[`HDR_CODE_LSB +: `HDR_CODE_W];
                    nxt_len = CMD_DATA[`HDR_LEN_LSB +: `HDR_LEN_W];
                    nxt_args_left = CMD_DATA[`HDR_LEN_LSB +: `HDR_LEN_W];
                    nxt_client = CMD_DATA[`HDR_CLIENT_LSB +: `HDR_CLIENT_W];
                    nxt_arg0 = `RST_WORD;
                    nxt_state = (CMD_DATA[`HDR_LEN_LSB +: `HDR_LEN_W] == `LEN_NONE) ? ST_EXEC : ST_ARGS;
                end
            end
            ST_ARGS: begin
                // Surplus argument words are drained so the stream stays aligned.
                if (take) begin
                    if (args_left_ff == len_ff) begin
                        nxt_arg0 = CMD_DATA;
                    end
                    nxt_args_left = args_left_ff - `LEN_ONE;
                    if (args_left_ff == `LEN_ONE) begin
                        nxt_state = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                case (code_ff)
                    `CMD_UPDATE_STATUS: begin
                        if (len_ff != `LEN_NONE) begin
                            verdict = `RESP_BAD_LENGTH;
                        end else begin
                            verdict_len = `RSP_LEN_STATUS;
                        end
                    end
                    `CMD_FLASH_CLAIM: begin
                        if (len_ff != `LEN_NONE) begin
                            verdict = `RESP_BAD_LENGTH;
                        end else if (owned_ff || CONFIG_BUSY) begin
                            verdict = `RESP_RESOURCE_BUSY;
                        end else begin
                            nxt_owned = 1'b1;
                            nxt_owner = client_ff;
                            nxt_selected = 1'b0;
                            verdict_len = `RSP_LEN_FLASH;
                        end
                    end
                    `CMD_FLASH_RELEASE: begin
                        if (len_ff != `LEN_NONE) begin
                            verdict = `RESP_BAD_LENGTH;
                        end else if (!is_owner) begin
                            verdict = `RESP_NOT_OWNER;
                        end else begin
                            nxt_owned = 1'b0;
                            nxt_selected = 1'b0;
                            nxt_sel = `RST_SEL;
                            verdict_len = `RSP_LEN_FLASH;
                        end
                    end
                    `CMD_FLASH_SELECT: begin
                        // Reserved low bits are ignored rather than refused.
                        if (len_ff != `LEN_ONE) begin
                            verdict = `RESP_BAD_LENGTH;
                        end else if (!is_owner) begin
                            verdict = `RESP_NOT_OWNER;
                        end else if (arg0_ff[`SEL_DEV_LSB +: `SEL_DEV_W] > `SEL_MAX) begin
                            verdict = `RESP_BAD_SELECT;
                        end else begin
                            nxt_sel = arg0_ff[`SEL_DEV_LSB +: 2];
                            nxt_selected = 1'b1;
                            verdict_len = `RSP_LEN_FLASH;
                        end
                    end
                    default: begin
                        verdict = `RESP_UNKNOWN_CMD;
                    end
                endcase
                nxt_body_status = (code_ff == `CMD_UPDATE_STATUS);
                nxt_rsp_len = verdict_len;
                nxt_rsp_idx = 4'h0;
                nxt_rsp_data = make_hdr(verdict, verdict_len, client_ff);
                nxt_rsp_last = (verdict_len == `RSP_LEN_ERROR);
                nxt_rsp_valid = 1'b1;
                nxt_state = ST_RESP;
            end
            ST_RESP: begin
                if (RSP_READY) begin
                    if (rsp_last_ff) begin
                        nxt_rsp_valid = 1'b0;
                        nxt_rsp_last = 1'b0;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_rsp_idx = rsp_idx_ff + 4'h1;
                        // Granted flash command answers carry one zero data word after the header.
                        nxt_rsp_data = body_status_ff ? sif.word : `RST_WORD;
                        nxt_rsp_last = ((rsp_idx_ff + 4'h1) == rsp_len_ff);
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_rsp_valid = 1'b0;
            end
        endcase
        nxt_cmd_ready = (nxt_state == ST_IDLE) || (nxt_state == ST_ARGS);
    end

    always_comb begin
        // Status words are read live while draining, so a word may change between beats.
        nxt_access_ok = nxt_owned && (nxt_selected || QUAD_SCHEME);
        nxt_cs_n = `CS_ALL_OFF;
        if (CONFIG_BUSY) begin
            if (CONFIG_FLASH_REQ) begin
                nxt_cs_n = cs_vector(`CS_CONFIG_LINE);
            end
        end else if (access_ok_ff && FLASH_XFER) begin
            nxt_cs_n = cs_vector(sel_ff);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state_ff <= ST_IDLE;
            code_ff <= `RESP_OK;
            len_ff <= `LEN_NONE;
            args_left_ff <= `LEN_NONE;
            client_ff <= 4'h0;
            arg0_ff <= `RST_WORD;
            cmd_ready_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= `RST_WORD;
            rsp_last_ff <= 1'b0;
            rsp_idx_ff <= 4'h0;
            rsp_len_ff <= 4'h0;
            body_status_ff <= 1'b0;
            owned_ff <= 1'b0;
            owner_ff <= 4'h0;
            sel_ff <= `RST_SEL;
            selected_ff <= 1'b0;
            access_ok_ff <= 1'b0;
            cs_n_ff <= `CS_ALL_OFF;
            exhausted_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            code_ff <= nxt_code;
            len_ff <= nxt_len;
            args_left_ff <= nxt_args_left;
            client_ff <= nxt_client;
            arg0_ff <= nxt_arg0;
            cmd_ready_ff <= nxt_cmd_ready;
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_data_ff <= nxt_rsp_data;
            rsp_last_ff <= nxt_rsp_last;
            rsp_idx_ff <= nxt_rsp_idx;
            rsp_len_ff <= nxt_rsp_len;
            body_status_ff <= nxt_body_status;
            owned_ff <= nxt_owned;
            owner_ff <= nxt_owner;
            sel_ff <= nxt_sel;
            selected_ff <= nxt_selected;
            access_ok_ff <= nxt_access_ok;
            cs_n_ff <= nxt_cs_n;
            exhausted_ff <= retry_exhausted;
        end
    end

    assign CMD_READY = cmd_ready_ff;
    assign RSP_VALID = rsp_valid_ff;
    assign RSP_DATA = rsp_data_ff;
    assign RSP_LAST = rsp_last_ff;
    assign RETRY_EXHAUSTED = exhausted_ff;
    assign FLASH_OWNED = owned_ff;
    assign FLASH_OWNER = owner_ff;
    assign FLASH_ACCESS_OK = access_ok_ff;
    assign FLASH_CHIP_SELECTS_N = cs_n_ff;
endmodule : upd_flash_mailbox

// ### dv/upd_flash_mailbox_checker.sv
// Purpose: Port-level checks of the mailbox command handler.
// Assumes: One clock; reset is synchronous and active low.
// Notes: Attached to every instance of the top module.
`timescale 1ns/100ps
module upd_flash_mailbox_checker (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CMD_VALID,
    input wire logic [31:0] CMD_DATA,
    input wire logic CMD_READY,
    input wire logic RSP_VALID,
    input wire logic [31:0] RSP_DATA,
    input wire logic RSP_LAST,
    input wire logic RSP_READY,
    input wire logic CONFIG_BUSY,
    input wire logic CONFIG_FLASH_REQ,
    input wire logic FLASH_OWNED,
    input wire logic [3:0] FLASH_OWNER,
    input wire logic [3:0] FLASH_CHIP_SELECTS_N
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    // Argument words carry zero in the code field, so only headers match a command code.
    logic take;
    assign take = CMD_VALID && CMD_READY;
    AST_STATUS_HDR: assert property (take && CMD_DATA[10:0] == 11'h05B && CMD_DATA[22:12] == 11'h000 |-> ##2
        RSP_VALID && RSP_DATA[10:0] == 11'h000 && RSP_DATA[22:12] == 11'h009) else $error("status header wrong");
    AST_CLAIM_OK: assert property (take && CMD_DATA[10:0] == 11'h032 && CMD_DATA[22:12] == 11'h000 &&
        !FLASH_OWNED && !CONFIG_BUSY |-> ##2 (RSP_VALID && RSP_DATA[10:0] == 11'h000) ##[0:3] FLASH_OWNED)
        else $error("claim not granted");
    AST_CLAIM_BUSY: assert property (take && CMD_DATA[10:0] == 11'h032 && CMD_DATA[22:12] == 11'h000 &&
        (FLASH_OWNED || CONFIG_BUSY) |-> ##2 RSP_VALID && RSP_DATA[10:0] == 11'h00B)
        else $error("busy claim not refused");
    AST_RSP_STANDS: assert property (RSP_VALID && !RSP_READY |=>
        RSP_VALID && $stable(RSP_DATA) && $stable(RSP_LAST)) else $error("response word dropped");
    AST_ONE_AT_A_TIME: assert property (RSP_VALID |-> !CMD_READY) else $error("command taken mid response");
    AST_OWNER_KEPT: assert property (FLASH_OWNED && CMD_READY |=>
        FLASH_OWNED && $stable(FLASH_OWNER)) else $error("ownership changed without command");
    AST_CFG_CS: assert property (CONFIG_BUSY && CONFIG_FLASH_REQ |=>
        FLASH_CHIP_SELECTS_N == 4'hE) else $error("config not on line zero");
    AST_CS_IDLE: assert property ((!FLASH_OWNED && !CONFIG_BUSY) [*3] |->
        FLASH_CHIP_SELECTS_N == 4'hF) else $error("chip select without owner");
    AST_SINGLE_CS: assert property ($onehot0(~FLASH_CHIP_SELECTS_N)) else $error("two chip selects low");
endmodule : upd_flash_mailbox_checker
bind upd_flash_mailbox upd_flash_mailbox_checker u_chk (.*);

// ### dv/mbox_client.sv
// Purpose: Mailbox client that sends one command and collects its answer.
// Assumes: Called just after a rising edge.
// Notes: Set slow to stall the answer every other cycle.
`timescale 1ns/100ps
module mbox_client (
    input wire logic clk,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [31:0] rsp_data,
    input wire logic rsp_last,
    output logic cmd_valid,
    output logic [31:0] cmd_data,
    output logic rsp_ready
);
    logic [31:0] rsp_w [0:15];
    int n_rsp = 0;
    bit slow = 1'b0;
    logic done;
    initial begin
        cmd_valid = 1'b0;
        cmd_data = 32'h0;
        rsp_ready = 1'b0;
    end
    task automatic send(input logic [31:0] w);
        cmd_valid = 1'b1;
        cmd_data = w;
        do @(posedge clk); while (!cmd_ready);
        #1;
    endtask : send
    task automatic run(input logic [31:0] hdr, input logic [31:0] arg, input bit has_arg);
        n_rsp = 0;
        done = 1'b0;
        send(hdr);
        if (has_arg) begin
            send(arg);
        end
        cmd_valid = 1'b0;
        // An idle bus must not look like the last word.
        cmd_data = ~cmd_data;
        rsp_ready = 1'b1;
        while (!done) begin
            @(posedge clk);
            if (rsp_valid && rsp_ready) begin
                rsp_w[n_rsp] = rsp_data;
                n_rsp++;
                done = rsp_last;
            end
            #1;
            rsp_ready = done ? 1'b0 : (slow ? ~rsp_ready : 1'b1);
        end
    endtask : run
endmodule : mbox_client

// ### dv/upd_flash_mailbox_tb.sv
// Purpose: Self-checking bench of the mailbox command handler.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Status words are checked against the live input levels.
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h exp %h", $time, (a), (e)); end end
module upd_flash_mailbox_tb
    import upd_mbox_pkg::*;
;
    logic ref_clk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_ready;
    word_t cmd_data, rsp_data, fail_state, err_loc, err_det;
    logic [3:0] dcmf_idx, owner, cs_n;
    logic [11:0] err_src;
    logic [7:0] if_ver;
    logic [63:0] cur_img, fail_img;
    logic retry_ev, new_img, exhausted, cfg_busy, cfg_req, quad, xfer, owned, acc_ok;
    logic [1:0] max_retry;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    upd_flash_mailbox u_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_DATA(cmd_data),
        .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_LAST(rsp_last),
        .RSP_READY(rsp_ready), .DCMF_INDEX(dcmf_idx), .ERR_SOURCE(err_src), .IF_VERSION(if_ver),
        .CUR_IMAGE(cur_img), .FAIL_IMAGE(fail_img), .FAIL_STATE(fail_state), .ERR_LOCATION(err_loc),
        .ERR_DETAILS(err_det), .RETRY_EVENT(retry_ev), .NEW_IMAGE(new_img), .MAX_RETRY(max_retry),
        .RETRY_EXHAUSTED(exhausted), .CONFIG_BUSY(cfg_busy), .CONFIG_FLASH_REQ(cfg_req), .QUAD_SCHEME(quad),
        .FLASH_XFER(xfer), .FLASH_OWNED(owned), .FLASH_OWNER(owner), .FLASH_ACCESS_OK(acc_ok),
        .FLASH_CHIP_SELECTS_N(cs_n));
    mbox_client u_cli (.clk(ref_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_last(rsp_last), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .rsp_ready(rsp_ready));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done();
        end
    end
    function automatic word_t hdr(logic [10:0] code, logic [10:0] len, logic [3:0] cl);
        return {4'h0, cl, 1'b0, len, 1'b0, code};
    endfunction : hdr
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_cyc
    task automatic cmd(input logic [10:0] code, input logic [3:0] cl, input word_t arg,
        input logic [10:0] exp_code, input logic [10:0] exp_len);
        u_cli.run(hdr(code, {10'h0, code == 11'h034}, cl), arg, code == 11'h034);
        `CHK(u_cli.rsp_w[0], hdr(exp_code, exp_len, cl))
        `CHK(u_cli.n_rsp, int'(exp_len) + 1)
    endtask : cmd
    task automatic pulse(input bit retry);
        retry_ev = retry;
        new_img = !retry;
        wait_cyc(1);
        retry_ev = 1'b0;
        new_img = 1'b0;
        wait_cyc(2);
    endtask : pulse
    task automatic status(input logic [11:0] src, input logic [1:0] retries);
        word_t exp [0:8];
        err_src = src;
        fail_img = (src == 12'h000) ? 64'h0 : 64'h0000_0011_2233_4400;
        exp = '{cur_img[31:0], cur_img[63:32], fail_img[31:0], fail_img[63:32], fail_state,
            {dcmf_idx, src, 8'h00, if_ver}, (src == 12'h000) ? 32'h0 : err_loc,
            (src == 12'h000) ? 32'h0 : err_det, {30'h0, retries}};
        cmd(11'h05B, 4'h2, 32'h0, 11'h000, 11'h009);
        for (int k = 0; k < 9; k++) begin
            `CHK(u_cli.rsp_w[k + 1], exp[k])
        end
    endtask : status
    initial begin
        {rst_n, retry_ev, new_img, cfg_busy, cfg_req, quad, xfer} = 7'h00;
        {dcmf_idx, if_ver, max_retry, err_src} = {4'hA, 8'h01, 2'h2, 12'h000};
        {cur_img, fail_img} = {64'h8765_4321_0FED_CBA9, 64'h0};
        {fail_state, err_loc, err_det} = {32'h0003_0002, 32'h0000_1234, 32'h5678_0000};
        wait_cyc(6);
        rst_n = 1'b1;
        wait_cyc(1);
        pulse(1'b0);
        `CHK(exhausted, 1'b0)
        max_retry = 2'h0;
        wait_cyc(2);
        `CHK(exhausted, 1'b1)
        max_retry = 2'h2;
        status(12'h000, 2'h0);
        status(12'hDCF, 2'h0);
        pulse(1'b1);
        `CHK(exhausted, 1'b1)
        max_retry = 2'h3;
        wait_cyc(2);
        `CHK(exhausted, 1'b0)
        max_retry = 2'h2;
        status(12'hACF, 2'h1);
        u_cli.slow = 1'b1;
        pulse(1'b1);
        status(12'hDCF, 2'h2);
        // A retry and a new image in one cycle count as a retry; the count then saturates.
        {retry_ev, new_img} = 2'h3;
        wait_cyc(1);
        pulse(1'b1);
        status(12'h000, 2'h3);
        u_cli.slow = 1'b0;
        cmd(11'h032, 4'h1, 32'h0, 11'h000, 11'h001);
        `CHK(owned, 1'b1)
        `CHK(owner, 4'h1)
        cmd(11'h032, 4'h2, 32'h0, 11'h00B, 11'h000);
        cmd(11'h034, 4'h2, 32'h0, 11'h100, 11'h000);
        cmd(11'h033, 4'h2, 32'h0, 11'h100, 11'h000);
        xfer = 1'b1;
        wait_cyc(2);
        `CHK(cs_n, 4'hF)
        quad = 1'b1;
        wait_cyc(2);
        `CHK(acc_ok, 1'b1)
        `CHK(cs_n, 4'hE)
        quad = 1'b0;
        for (int d = 0; d < 4; d++) begin
            cmd(11'h034, 4'h1, {d[3:0], 28'h0}, 11'h000, 11'h001);
            wait_cyc(2);
            `CHK(cs_n, ~(4'h1 << d))
        end
        cmd(11'h034, 4'h1, {4'h4, 28'h0}, 11'h101, 11'h000);
        cmd(11'h033, 4'h1, 32'h0, 11'h000, 11'h001);
        wait_cyc(2);
        `CHK(owned, 1'b0)
        `CHK(cs_n, 4'hF)
        {cfg_busy, cfg_req} = 2'h3;
        wait_cyc(2);
        `CHK(cs_n, 4'hE)
        cmd(11'h032, 4'h3, 32'h0, 11'h00B, 11'h000);
        {cfg_busy, cfg_req} = 2'h0;
        cmd(11'h077, 4'h1, 32'h0, 11'h003, 11'h000);
        test_done();
    end
endmodule : upd_flash_mailbox_tb
